//--- dv/nvi_core_model.sv
`timescale 1ns/1ps
// ==========
// Core side: takes a request after LAT cycles, returns after HOLD
module nvi_core_model
  import nvi_pkg::*;
#(
  parameter int LAT  = 4,
  parameter int HOLD = 40
)(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic       i_req,
  input  wire logic [7:0] i_req_id,
  input  wire logic       i_nmi_req,
  output logic            o_ack,
  output logic            o_exit,
  output logic [7:0]      o_exit_id
);
  int   cnt_reg;
  logic busy_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ack     <= 1'b0;
      o_exit    <= 1'b0;
      cnt_reg   <= 0;
      busy_reg  <= 1'b0;
      o_exit_id <= NVI_ID_NONE;
    end else if (busy_reg) begin
      o_ack    <= 1'b0;
      o_exit   <= (cnt_reg == HOLD);
      busy_reg <= (cnt_reg != HOLD);
      cnt_reg  <= (cnt_reg == HOLD) ? 0 : cnt_reg + 1;
    end else if (i_go && (i_req || i_nmi_req) && !o_ack) begin
      // No exit for nmi: it has no line number to return
      o_ack    <= (cnt_reg == LAT);
      o_exit   <= 1'b0;
      busy_reg <= (cnt_reg == LAT) && i_req;
      cnt_reg  <= (cnt_reg == LAT) ? 0 : cnt_reg + 1;
      if (cnt_reg == LAT) begin
        o_exit_id <= i_req_id;
      end
    end else begin
      o_ack  <= 1'b0;
      o_exit <= 1'b0;
    end
  end
endmodule

//--- dv/nvi_ctrl_chk.sv
`timescale 1ns/1ps
// ==========
// Port checker
module nvi_ctrl_chk
  import nvi_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_nmi,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_priv,
  input wire logic        i_ack,
  input wire logic [31:0] o_rdata,
  input wire logic        o_req,
  input wire logic [7:0]  o_req_id,
  input wire logic        o_nmi_req
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_rdata_slot_only: assert property (!$past(i_rd && i_priv) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  a_rst_quiet: assert property ($fell(i_rst) |-> !o_req && !o_nmi_req && o_rdata == 32'h0)
    else $error("outputs busy after reset");
  a_take_drops: assert property (o_req && i_ack |=> !o_req)
    else $error("request held after take");
  a_idle_id_none: assert property (!o_req |-> o_req_id == NVI_ID_NONE)
    else $error("id shown without request");
  a_id_in_range: assert property (o_req |-> o_req_id < 8'(NVI_NUM_IRQ))
    else $error("request for unimplemented line");
  a_ack_retires_id: assert property (o_req && i_ack |-> ##2 (!o_req || o_req_id != $past(o_req_id, 2)))
    else $error("active interrupt requested again");
  a_nmi_seen: assert property ($rose(i_nmi) |-> ##[1:6] o_nmi_req)
    else $error("nmi edge not raised");
  a_nmi_holds: assert property (o_nmi_req && !i_ack && !$past(i_ack) |=> o_nmi_req)
    else $error("nmi dropped without ack");
  a_clr_en_blocks: assert property (i_wr && i_priv && i_addr == NVI_EN_CLR_BASE &&
    i_wdata == 32'hffff_ffff |-> ##2 !(o_req && o_req_id < 8'h20))
    else $error("disabled interrupt requested");
endmodule
bind nvi_ctrl nvi_ctrl_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_nmi(i_nmi),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_priv(i_priv),
  .i_ack(i_ack), .o_rdata(o_rdata), .o_req(o_req), .o_req_id(o_req_id),
  .o_nmi_req(o_nmi_req));

//--- dv/tb_nvi_ctrl.sv
`timescale 1ns/1ps
module tb_nvi_ctrl;
  import nvi_pkg::*;
  logic clk = 0, rst = 1, nmi = 0, wr = 0, rd = 0, priv = 1, go = 0;
  logic [NVI_NUM_IRQ-1:0] irq = '0;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic req, nmi_req, ack, ext;
  logic [7:0] req_id, ext_id;
  logic [3:0] req_prio;
  int err_total = 0, n_checks = 0;
  initial forever #2.5 clk = ~clk;
  nvi_ctrl u_dut (.i_ref_clk(clk), .i_rst(rst), .i_irq(irq), .i_nmi(nmi), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_priv(priv), .i_ack(ack), .i_exit(ext),
    .i_exit_id(ext_id), .o_rdata(rdata), .o_req(req), .o_req_id(req_id),
    .o_req_prio(req_prio), .o_nmi_req(nmi_req));
  nvi_core_model u_core (.i_ref_clk(clk), .i_rst(rst), .i_go(go), .i_req(req),
    .i_req_id(req_id), .i_nmi_req(nmi_req), .o_ack(ack), .o_exit(ext), .o_exit_id(ext_id));
  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrr(input logic [31:0] a, d, input logic p = 1'b1);
    @(posedge clk); addr <= a; wdata <= d; priv <= p; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; priv <= 1'b1;
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, exp, input logic p = 1'b1);
    @(posedge clk); addr <= a; priv <= p; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; priv <= 1'b1;
    #1 chk(nm, rdata, exp);
  endtask
  task automatic wait_on(input string nm, input int k);
    logic s;
    s = 1'b0;
    for (int i = 0; i < 60 && s !== 1'b1; i++) begin
      @(posedge clk); #1;
      s = (k == 0) ? ack : (k == 1) ? ext : nmi_req;
    end
    chk(nm, {31'h0, s}, 1);
  endtask
  task automatic wait_req(input logic [7:0] id, input logic [3:0] pr);
    #1;
    for (int i = 0; i < 20 && !(req === 1'b1 && req_id === id); i++) begin @(posedge clk); #1; end
    chk("req_id", {24'h0, req_id}, {24'h0, id});
    chk("req_prio", {28'h0, req_prio}, {28'h0, pr});
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    for (int g = 0; g < 5; g++)
      for (int w = 0; w < 3; w++) rdc("reset", NVI_EN_SET_BASE + 32'(g * 128 + w * 4), 0);
    for (int w = 0; w < 3; w++) begin
      wrr(NVI_EN_SET_BASE + 32'(w * 4), 32'hffff_ffff);
      rdc("en_set", NVI_EN_SET_BASE + 32'(w * 4), w == 2 ? 32'h0001_ffff : '1);
      rdc("en_clr", NVI_EN_CLR_BASE + 32'(w * 4), w == 2 ? 32'h0001_ffff : '1);
    end
    wrr(NVI_EN_CLR_BASE + 4, 32'h0000_0100);
    wrr(NVI_EN_SET_BASE + 4, 32'h0000_0000);
    rdc("en_clr1", NVI_EN_SET_BASE + 4, 32'hffff_feff);
    for (int w = 0; w < 3; w++) wrr(NVI_EN_CLR_BASE + 32'(w * 4), 32'hffff_ffff);
    wrr(NVI_PEND_SET_BASE + 4, 32'h0000_0005);
    wrr(NVI_PEND_SET_BASE + 4, 32'h0000_0001);
    rdc("pend_set", NVI_PEND_SET_BASE + 4, 32'h0000_0005);
    repeat (4) @(posedge clk);
    #1 chk("no_req", {31'h0, req}, 0);
    wrr(NVI_PEND_CLR_BASE + 4, 32'h0000_0001);
    rdc("pend_clr", NVI_PEND_CLR_BASE + 4, 32'h0000_0004);
    wrr(NVI_PEND_CLR_BASE + 4, 32'h0000_0004);
    wrr(NVI_EN_SET_BASE, 32'h0000_0001, 1'b0);
    rdc("unpriv_wr", NVI_EN_SET_BASE, 0);
    wrr(NVI_EN_SET_BASE + 8, 32'h0000_0001);
    rdc("unpriv_rd", NVI_EN_SET_BASE + 8, 0, 1'b0);
    rdc("unmapped", NVI_PRIO_BASE + 32'h54, 0);
    wrr(NVI_EN_CLR_BASE + 8, 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_prio();
    wrr(NVI_PRIO_BASE, 32'h1234_5678);
    rdc("prio", NVI_PRIO_BASE, 32'h1030_5070);
    wrr(NVI_PEND_SET_BASE, 32'h0000_000f);
    wrr(NVI_EN_SET_BASE, 32'h0000_000f);
    wait_req(8'd3, 4'h1);
    wrr(NVI_PRIO_BASE, 32'h1030_5000);
    wait_req(8'd0, 4'h0);
    wrr(NVI_EN_CLR_BASE, 32'hffff_ffff);
    wrr(NVI_PEND_CLR_BASE, 32'h0000_000f);
    $display("test prio done");
  endtask
  task automatic t_line();
    @(posedge clk); go <= 1'b1;
    wrr(NVI_EN_SET_BASE + 4, 32'h0000_0100);
    @(posedge clk); irq[40] <= 1'b1;
    wait_req(8'd40, 4'h0);
    wait_on("ack", 0);
    repeat (3) @(posedge clk);
    rdc("active", NVI_ACTIVE_BASE + 4, 32'h0000_0100);
    wrr(NVI_PEND_CLR_BASE + 4, 32'h0000_0100);
    rdc("act_kept", NVI_ACTIVE_BASE + 4, 32'h0000_0100);
    @(posedge clk); irq[40] <= 1'b0;
    wait_on("exit", 1);
    repeat (4) @(posedge clk);
    rdc("inactive", NVI_ACTIVE_BASE + 4, 0);
    wrr(NVI_EN_SET_BASE + 8, 32'h0000_0040);
    @(posedge clk); irq[70] <= 1'b1;
    repeat (3) @(posedge clk); irq[70] <= 1'b0;
    wait_req(8'd70, 4'h0);
    repeat (60) @(posedge clk);
    rdc("pulse_once", NVI_PEND_SET_BASE + 8, 0);
    @(posedge clk); nmi <= 1'b1;
    repeat (3) @(posedge clk); nmi <= 1'b0;
    wait_on("nmi", 2);
    chk("nmi_req", {31'h0, nmi_req}, 1);
    repeat (12) @(posedge clk);
    #1 chk("nmi_taken", {31'h0, nmi_req}, 0);
    $display("test line done");
  endtask
  task automatic t_soft();
    @(posedge clk); go <= 1'b0;
    wrr(NVI_SOFT_TRIG, 32'h0000_0050);
    wrr(NVI_SOFT_TRIG, 32'h0000_00a5);
    rdc("trig", NVI_PEND_SET_BASE + 8, 32'h0001_0000);
    rdc("trig_hi", NVI_PEND_SET_BASE + 4, 0);
    wrr(NVI_GROUP_CFG, 32'h0000_0007);
    rdc("grp", NVI_GROUP_CFG, 32'h0000_0004);
    wrr(NVI_PEND_SET_BASE, 32'h0000_0020);
    wrr(NVI_EN_SET_BASE, 32'h0000_0020);
    wait_req(8'd5, 4'h0);
    rdc("status", NVI_STATUS, 32'h0000_0205);
    @(posedge clk); rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc("rst_en", NVI_EN_SET_BASE, 0);
    rdc("rst_pend", NVI_PEND_SET_BASE + 8, 0);
    $display("test soft done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prio();
    t_line();
    t_soft();
    finish_test();
  end
  // Whole run is about 280 cycles
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule

//--- rtl/nvi_ctrl.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module nvi_ctrl
  import nvi_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic [NVI_NUM_IRQ-1:0] i_irq,
  input  wire logic              i_nmi,
  input  wire logic [31:0]       i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic              i_priv,
  input  wire logic              i_ack,
  input  wire logic              i_exit,
  input  wire logic [7:0]        i_exit_id,
  output logic [31:0]            o_rdata,
  output logic                   o_req,
  output logic [7:0]             o_req_id,
  output logic [NVI_PRIO_W-1:0]  o_req_prio,
  output logic                   o_nmi_req
);

  // ==========================================================
  // Input synchronisers
  logic [NVI_NUM_IRQ-1:0] irq_meta_reg;
  logic [NVI_NUM_IRQ-1:0] irq_sync_reg;
  logic [NVI_NUM_IRQ-1:0] irq_prev_reg;
  logic                   nmi_meta_reg;
  logic                   nmi_sync_reg;
  logic                   nmi_prev_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      irq_prev_reg <= '0;
      nmi_meta_reg <= 1'b0;
      nmi_sync_reg <= 1'b0;
      nmi_prev_reg <= 1'b0;
    end else begin
      irq_meta_reg <= i_irq;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
      nmi_meta_reg <= i_nmi;
      nmi_sync_reg <= nmi_meta_reg;
      nmi_prev_reg <= nmi_sync_reg;
    end
  end

  // ==========================================================
  // State
  logic [NVI_NUM_IRQ-1:0]  enable_reg;
  logic [NVI_NUM_IRQ-1:0]  pending_reg;
  logic [NVI_NUM_IRQ-1:0]  active_reg;
  logic [NVI_PRIO_W-1:0]   prio_reg [NVI_NUM_IRQ];
  logic [2:0]              group_reg;

  // ==========================================================
  // Address decode
  logic        acc_ok;
  logic [29:0] word_addr;
  logic [7:0]  widx;

  assign acc_ok    = i_priv;
  assign word_addr = i_addr[31:2];

  // Address passed in so callers re-evaluate when it moves
  function automatic logic in_win(input logic [29:0] wa, input logic [31:0] base,
                                  input int n);
    logic [29:0] b;
    b = base[31:2];
    return (wa >= b) && (wa < b + 30'(n));
  endfunction

  logic wr_ok;
  logic hit_en_set;
  logic hit_en_clr;
  logic hit_pd_set;
  logic hit_pd_clr;
  logic hit_act;
  logic hit_prio;
  logic hit_trig;
  logic hit_grp;
  logic hit_stat;

  assign wr_ok      = i_wr && acc_ok;
  assign hit_en_set = in_win(word_addr, NVI_EN_SET_BASE, NVI_NUM_WORDS);
  assign hit_en_clr = in_win(word_addr, NVI_EN_CLR_BASE, NVI_NUM_WORDS);
  assign hit_pd_set = in_win(word_addr, NVI_PEND_SET_BASE, NVI_NUM_WORDS);
  assign hit_pd_clr = in_win(word_addr, NVI_PEND_CLR_BASE, NVI_NUM_WORDS);
  assign hit_act    = in_win(word_addr, NVI_ACTIVE_BASE, NVI_NUM_WORDS);
  assign hit_prio   = in_win(word_addr, NVI_PRIO_BASE, NVI_NUM_PRIO);
  assign hit_trig   = (word_addr == NVI_SOFT_TRIG[31:2]);
  assign hit_grp    = (word_addr == NVI_GROUP_CFG[31:2]);
  assign hit_stat   = (word_addr == NVI_STATUS[31:2]);
  assign widx       = 8'(word_addr[4:0]);

  // Write data placed at the selected word of the 96 bit positions of a group
  logic [NVI_NUM_IRQ-1:0] wmask;
  always_comb begin
    logic [95:0] wide;
    wide = '0;
    wide[32*word_addr[1:0] +: 32] = i_wdata;
    wmask = wide[NVI_NUM_IRQ-1:0];
  end

  // Software trigger decode
  logic [NVI_NUM_IRQ-1:0] trig_mask;
  always_comb begin
    trig_mask = '0;
    if (wr_ok && hit_trig && (i_wdata[NVI_TRIG_ID_W-1:0] < NVI_TRIG_ID_W'(NVI_NUM_IRQ))) begin
      trig_mask[i_wdata[6:0]] = 1'b1;
    end
  end

  // ==========================================================
  // Enable bits
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      enable_reg <= '0;
    end else if (wr_ok && hit_en_set) begin
      enable_reg <= enable_reg | wmask;
    end else if (wr_ok && hit_en_clr) begin
      enable_reg <= enable_reg & ~wmask;
    end
  end

  // ==========================================================
  // Arbitration: lowest group, then lowest subpriority, then lowest number
  logic [NVI_NUM_IRQ-1:0] cand;
  logic                   win_vld;
  logic [7:0]             win_id;
  logic [NVI_PRIO_W-1:0]  win_prio;
  logic [NVI_PRIO_W-1:0]  grp_mask;

  // Group config N: top (4-N) bits are group, rest subpriority
  assign grp_mask = NVI_PRIO_W'(4'hf << group_reg);
  assign cand     = pending_reg & enable_reg & ~active_reg;

  always_comb begin
    logic [NVI_PRIO_W-1:0] g;
    logic [NVI_PRIO_W-1:0] bg;
    g        = '0;
    bg       = '0;
    win_vld  = 1'b0;
    win_id   = NVI_ID_NONE;
    win_prio = '0;
    for (int i = 0; i < NVI_NUM_IRQ; i++) begin
      g = prio_reg[i] & grp_mask;
      // Strict less-than keeps lower numbers ahead on a full tie
      if (cand[i] && (!win_vld || g < bg || (g == bg && prio_reg[i] < win_prio))) begin
        win_vld  = 1'b1;
        win_id   = 8'(i);
        win_prio = prio_reg[i];
        bg       = g;
      end
    end
  end

  // ==========================================================
  // Core handshake decode
  logic irq_take;
  logic nmi_take;

  // An ack with no line offered belongs to the non-maskable request
  assign irq_take = i_ack && o_req;
  assign nmi_take = i_ack && !o_req;

  // ==========================================================
  // Pending bits
  logic [NVI_NUM_IRQ-1:0] ack_mask;
  logic [NVI_NUM_IRQ-1:0] exit_mask;
  logic [NVI_NUM_IRQ-1:0] hw_set;

  always_comb begin
    ack_mask  = '0;
    exit_mask = '0;
    if (irq_take && o_req_id < 8'(NVI_NUM_IRQ)) begin
      ack_mask[o_req_id[6:0]] = 1'b1;
    end
    if (i_exit && i_exit_id < 8'(NVI_NUM_IRQ)) begin
      exit_mask[i_exit_id[6:0]] = 1'b1;
    end
  end

  // Level high while neither active nor being taken, level high on its own return, or any rising edge
  assign hw_set = (irq_sync_reg & ~(active_reg | ack_mask))
                | (irq_sync_reg & ~irq_prev_reg)
                | (irq_sync_reg & exit_mask);

  // Software set and clear, already gated by privilege and window
  logic [NVI_NUM_IRQ-1:0] sw_set;
  logic [NVI_NUM_IRQ-1:0] sw_clr;
  logic [NVI_NUM_IRQ-1:0] pending_next;

  assign sw_set = (wr_ok && hit_pd_set) ? wmask : '0;
  assign sw_clr = (wr_ok && hit_pd_clr) ? wmask : '0;

  // Sets win over clears so a fresh event is never lost
  assign pending_next = (pending_reg & ~ack_mask & ~sw_clr)
                      | sw_set
                      | trig_mask
                      | hw_set;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // ==========================================================
  // Active bits, driven by core entry and return
  logic [NVI_NUM_IRQ-1:0] active_next;

  // Entry wins over return so a fresh take is never lost
  assign active_next = (active_reg & ~exit_mask) | ack_mask;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      active_reg <= '0;
    end else begin
      active_reg <= active_next;
    end
  end

  // ==========================================================
  // Priority and grouping
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NVI_NUM_IRQ; i++) begin
        prio_reg[i] <= '0;
      end
    end else if (wr_ok && hit_prio) begin
      for (int b = 0; b < 4; b++) begin
        if (int'(widx) * 4 + b < NVI_NUM_IRQ) begin
          prio_reg[int'(widx) * 4 + b] <= i_wdata[8*b+NVI_PRIO_FIELD_LO +: NVI_PRIO_W];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      group_reg <= NVI_GROUP_RESET;
    end else if (wr_ok && hit_grp) begin
      group_reg <= (i_wdata[2:0] > 3'(NVI_SUB_W_MAX)) ? 3'(NVI_SUB_W_MAX) : i_wdata[2:0];
    end
  end

  // ==========================================================
  // Read path
  logic [31:0] rd_next;
  always_comb begin
    logic [95:0] en_w;
    logic [95:0] pd_w;
    logic [95:0] ac_w;
    logic [31:0] pw;
    en_w    = 96'(enable_reg);
    pd_w    = 96'(pending_reg);
    ac_w    = 96'(active_reg);
    pw      = '0;
    rd_next = NVI_RESET_WORD;
    for (int b = 0; b < 4; b++) begin
      if (int'(widx) * 4 + b < NVI_NUM_IRQ) begin
        pw[8*b+NVI_PRIO_FIELD_LO +: NVI_PRIO_W] = prio_reg[int'(widx) * 4 + b];
      end
    end
    if (!acc_ok) begin
      rd_next = NVI_RESET_WORD;
    end else if (hit_en_set || hit_en_clr) begin
      rd_next = en_w[32*word_addr[1:0] +: 32];
    end else if (hit_pd_set || hit_pd_clr) begin
      rd_next = pd_w[32*word_addr[1:0] +: 32];
    end else if (hit_act) begin
      rd_next = ac_w[32*word_addr[1:0] +: 32];
    end else if (hit_prio) begin
      rd_next = pw;
    end else if (hit_grp) begin
      rd_next = {29'h0, group_reg};
    end else if (hit_stat) begin
      rd_next = {22'h0, win_vld, o_nmi_req, win_id};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_next : '0;
    end
  end

  // ==========================================================
  // Core request
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_req      <= 1'b0;
      o_req_id   <= NVI_ID_NONE;
      o_req_prio <= '0;
    end else if (irq_take) begin
      // Drop for one cycle so the taken line is not offered twice
      o_req      <= 1'b0;
      o_req_id   <= NVI_ID_NONE;
      o_req_prio <= '0;
    end else begin
      o_req      <= win_vld;
      o_req_id   <= win_id;
      o_req_prio <= win_prio;
    end
  end

  // Stacking itself is left to the core once o_req is taken
  // Non-maskable: edge held until core takes it, no enable gates it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_nmi_req <= 1'b0;
    end else if (nmi_sync_reg && !nmi_prev_reg) begin
      o_nmi_req <= 1'b1;
    end else if (nmi_take) begin
      o_nmi_req <= 1'b0;
    end
  end

endmodule

//--- rtl/nvi_pkg.sv
package nvi_pkg;
  // ==========================================================
  // Sizes
  localparam int          NVI_NUM_IRQ   = 81;
  localparam int          NVI_NUM_WORDS = 3;
  localparam int          NVI_NUM_PRIO  = 21;
  localparam int          NVI_PRIO_W    = 4;
  localparam int          NVI_SUB_W_MAX = 4;
  localparam logic [7:0]  NVI_ID_NONE   = 8'hff;
  // ==========================================================
  // Register map, byte addresses
  localparam logic [31:0] NVI_EN_SET_BASE   = 32'he000_e100;
  localparam logic [31:0] NVI_EN_CLR_BASE   = 32'he000_e180;
  localparam logic [31:0] NVI_PEND_SET_BASE = 32'he000_e200;
  localparam logic [31:0] NVI_PEND_CLR_BASE = 32'he000_e280;
  localparam logic [31:0] NVI_ACTIVE_BASE   = 32'he000_e300;
  localparam logic [31:0] NVI_PRIO_BASE     = 32'he000_e400;
  localparam logic [31:0] NVI_SOFT_TRIG     = 32'he000_ef00;
  localparam logic [31:0] NVI_GROUP_CFG     = 32'he000_ef04;
  localparam logic [31:0] NVI_STATUS        = 32'he000_ef08;
  // ==========================================================
  // Reset values and fields
  localparam logic [31:0] NVI_RESET_WORD   = 32'h0000_0000;
  localparam logic [2:0]  NVI_GROUP_RESET  = 3'h0;
  localparam int          NVI_PRIO_FIELD_LO = 4;
  localparam int          NVI_TRIG_ID_W     = 9;
endpackage
